// ---- dbef_pkg.sv ----
package dbef_pkg;
	// buffer count and lane geometry
	localparam int NUM_BUF = 4;
	localparam int LANE_W = 8;
	localparam int REG_W = 32;
	localparam int THR_W = 16;
	// bit positions inside one byte lane, same order in every lane
	localparam int BIT_CELL = 7;
	localparam int BIT_REL = 6;
	localparam int BIT_EXP = 5;
	localparam int BIT_MARK_B = 4;
	localparam int BIT_MARK_A = 3;
	localparam int BIT_RSVD = 2;
	localparam int BIT_FULL = 1;
	localparam int BIT_EMPTY = 0;
	// lane whose empty flag comes out of reset high
	localparam int EMPTY_SET_LANE = 2;
	// summary and direction bit positions
	localparam int SUM_LOWER = 0;
	localparam int SUM_UPPER = 1;
	localparam int DIR_B_BASE = 4;
	// register byte offsets
	localparam logic [11:0] OFF_LEVEL_STATUS = 12'h144;
	localparam logic [11:0] OFF_EVENT_FLAGS = 12'h14c;
	localparam logic [11:0] OFF_EVENT_ENABLES = 12'h150;
	localparam logic [11:0] OFF_IRQ_SUMMARY = 12'h154;
	localparam logic [11:0] OFF_THRESH_BASE = 12'h160;
	localparam logic [11:0] OFF_DIR_SELECT = 12'h170;
	localparam logic [11:0] THRESH_STRIDE = 12'h004;
	// reset values and masks
	localparam logic [31:0] FLAGS_RESET = 32'h0001_0000;
	localparam logic [31:0] ENABLES_RESET = 32'h0001_0000;
	localparam logic [31:0] RSVD_MASK = 32'h0404_0404;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [7:0] DIR_MASK = 8'hff;
	// AXI response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- dbef_mark_if.sv ----
`timescale 1ns/1ps
interface dbef_mark_if #(
	parameter int NUM_BUF = 4,
	parameter int CNT_W = 12,
	parameter int THR_W = 16
);
	logic [NUM_BUF*CNT_W-1:0] count;
	logic [NUM_BUF*THR_W-1:0] thr_a;
	logic [NUM_BUF*THR_W-1:0] thr_b;
	logic [NUM_BUF-1:0] dir_a;
	logic [NUM_BUF-1:0] dir_b;
	logic [NUM_BUF-1:0] stat_a;
	logic [NUM_BUF-1:0] stat_b;
	logic [NUM_BUF-1:0] rise_a;
	logic [NUM_BUF-1:0] rise_b;
	// register side drives settings, reads status and edges
	modport ctrl(output count, thr_a, thr_b, dir_a, dir_b, input stat_a, stat_b, rise_a, rise_b);
	// comparator side
	modport mark(input count, thr_a, thr_b, dir_a, dir_b, output stat_a, stat_b, rise_a, rise_b);
endinterface

// ---- dbef_watermark.sv ----
`timescale 1ns/1ps
module dbef_watermark
	import dbef_pkg::*;
#(
	parameter int CNT_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// settings in, status out
	dbef_mark_if.mark mk
);
	// a count wider than the threshold would be cut in the compare
	if (CNT_W < 1 || CNT_W > THR_W) begin : g_bad_cnt
		$error("dbef_watermark: CNT_W out of range");
	end

	// dir 0 trips above the threshold, dir 1 trips below it
	function automatic logic mark_hit(input logic [CNT_W-1:0] cnt, input logic [THR_W-1:0] thr,
			input logic dir);
		logic [THR_W-1:0] wide;
		wide = THR_W'(cnt);
		mark_hit = dir ? (wide < thr) : (wide > thr);
	endfunction

	logic [NUM_BUF-1:0] cmp_a;
	logic [NUM_BUF-1:0] cmp_b;
	logic [NUM_BUF-1:0] stat_a_ff;
	logic [NUM_BUF-1:0] stat_b_ff;
	logic [NUM_BUF-1:0] rise_a_ff;
	logic [NUM_BUF-1:0] rise_b_ff;

	// each buffer compares only its own count and thresholds
	genvar b;
	generate
		for (b = 0; b < NUM_BUF; b++) begin : g_cmp
			assign cmp_a[b] = mark_hit(mk.count[b*CNT_W +: CNT_W], mk.thr_a[b*THR_W +: THR_W],
				mk.dir_a[b]);
			assign cmp_b[b] = mark_hit(mk.count[b*CNT_W +: CNT_W], mk.thr_b[b*THR_W +: THR_W],
				mk.dir_b[b]);
		end
	endgenerate

	// status level plus a one-cycle pulse on its 0-to-1 edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_a_ff <= '0;
			stat_b_ff <= '0;
			rise_a_ff <= '0;
			rise_b_ff <= '0;
		end else begin
			stat_a_ff <= cmp_a;
			stat_b_ff <= cmp_b;
			rise_a_ff <= cmp_a & ~stat_a_ff;
			rise_b_ff <= cmp_b & ~stat_b_ff;
		end
	end

	assign mk.stat_a = stat_a_ff;
	assign mk.stat_b = stat_b_ff;
	assign mk.rise_a = rise_a_ff;
	assign mk.rise_b = rise_b_ff;
endmodule // dbef_watermark

// ---- dbef_top.sv ----
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dbef_top
	import dbef_pkg::*;
#(
	parameter int CNT_W = 12,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// buffer events, one-cycle pulses per buffer
	input wire logic [3:0] cell_committed,
	input wire logic [3:0] stamp_release,
	input wire logic [3:0] stamp_expired,
	// buffer levels
	input wire logic [3:0] no_space,
	input wire logic [3:0] no_data,
	input wire logic [4*CNT_W-1:0] level_count,
	// summary interrupt lines
	output logic irq_upper,
	output logic irq_lower
);
	// refuse widths that the decode and the comparators cannot serve
	if (CNT_W < 1 || CNT_W > THR_W) begin : g_bad_cnt
		$error("dbef_top: CNT_W out of range");
	end
	if (ADDR_W < 9) begin : g_bad_addr
		$error("dbef_top: ADDR_W too small for the register map");
	end

	localparam int LOWER_W = (NUM_BUF / 2) * LANE_W;
	localparam int TOP_BIT = NUM_BUF * LANE_W - 1;

	// word address match, shared by read and write decode
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [11:0] off);
		reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(off >> 2));
	endfunction

	// byte-lane merge for writable registers
	function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		strb_merge = res;
	endfunction

	// comparator carrier
	dbef_mark_if #(.NUM_BUF(NUM_BUF), .CNT_W(CNT_W), .THR_W(THR_W)) mk ();

	// register state
	logic [31:0] flags_ff;
	logic [31:0] enables_ff;
	logic [1:0] summary_ff;
	logic [31:0] thresh_ff [NUM_BUF];
	logic [7:0] dir_ff;
	logic [31:0] nxt_flags;
	logic [31:0] nxt_enables;
	logic [1:0] nxt_summary;

	// bus state
	logic aw_held_ff;
	logic [ADDR_W-1:0] awaddr_ff;
	logic w_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic irq_upper_ff;
	logic irq_lower_ff;

	// settings to the comparators
	genvar b;
	generate
		for (b = 0; b < NUM_BUF; b++) begin : g_set
			assign mk.thr_a[b*THR_W +: THR_W] = thresh_ff[b][THR_W-1:0];
			assign mk.thr_b[b*THR_W +: THR_W] = thresh_ff[b][2*THR_W-1:THR_W];
		end
	endgenerate
	assign mk.count = level_count;
	assign mk.dir_a = dir_ff[NUM_BUF-1:0];
	assign mk.dir_b = dir_ff[DIR_B_BASE +: NUM_BUF];

	dbef_watermark #(.CNT_W(CNT_W)) u_mark (
		.aclk(aclk),
		.aresetn(aresetn),
		.mk(mk)
	);

	// hardware set terms, one byte lane per buffer
	logic [31:0] set_vec;
	logic [31:0] level_vec;
	generate
		for (b = 0; b < NUM_BUF; b++) begin : g_lane
			assign set_vec[b*LANE_W+BIT_CELL] = cell_committed[b];
			assign set_vec[b*LANE_W+BIT_REL] = stamp_release[b];
			assign set_vec[b*LANE_W+BIT_EXP] = stamp_expired[b];
			assign set_vec[b*LANE_W+BIT_MARK_B] = mk.rise_b[b];
			assign set_vec[b*LANE_W+BIT_MARK_A] = mk.rise_a[b];
			assign set_vec[b*LANE_W+BIT_RSVD] = 1'b0;
			assign set_vec[b*LANE_W+BIT_FULL] = no_space[b];
			assign set_vec[b*LANE_W+BIT_EMPTY] = no_data[b];
			// live view for the level status register
			assign level_vec[b*LANE_W+BIT_CELL] = 1'b0;
			assign level_vec[b*LANE_W+BIT_REL] = 1'b0;
			assign level_vec[b*LANE_W+BIT_EXP] = 1'b0;
			assign level_vec[b*LANE_W+BIT_MARK_B] = mk.stat_b[b];
			assign level_vec[b*LANE_W+BIT_MARK_A] = mk.stat_a[b];
			assign level_vec[b*LANE_W+BIT_RSVD] = 1'b0;
			assign level_vec[b*LANE_W+BIT_FULL] = no_space[b];
			assign level_vec[b*LANE_W+BIT_EMPTY] = no_data[b];
		end
	endgenerate

	// handshakes
	wire aw_take = s_axi_awvalid & awready_ff;
	wire w_take = s_axi_wvalid & wready_ff;
	wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire ar_take = s_axi_arvalid & arready_ff;
	wire b_done = bvalid_ff & s_axi_bready;
	wire r_done = rvalid_ff & s_axi_rready;

	// write decode on the held address
	wire wr_status = reg_hit(awaddr_ff, OFF_LEVEL_STATUS);
	wire wr_flags = reg_hit(awaddr_ff, OFF_EVENT_FLAGS);
	wire wr_enables = reg_hit(awaddr_ff, OFF_EVENT_ENABLES);
	wire wr_summary = reg_hit(awaddr_ff, OFF_IRQ_SUMMARY);
	wire wr_dir = reg_hit(awaddr_ff, OFF_DIR_SELECT);
	logic [NUM_BUF-1:0] wr_thresh;
	logic [NUM_BUF-1:0] rd_thresh;
	generate
		for (b = 0; b < NUM_BUF; b++) begin : g_thr_dec
			assign wr_thresh[b] = reg_hit(awaddr_ff, 12'(OFF_THRESH_BASE + b * THRESH_STRIDE));
			assign rd_thresh[b] = reg_hit(s_axi_araddr, 12'(OFF_THRESH_BASE + b * THRESH_STRIDE));
		end
	endgenerate
	wire wr_mapped = wr_status | wr_flags | wr_enables | wr_summary | wr_dir | (|wr_thresh);

	// read decode on the live address, taken only in the accept cycle
	wire rd_status = reg_hit(s_axi_araddr, OFF_LEVEL_STATUS);
	wire rd_flags = reg_hit(s_axi_araddr, OFF_EVENT_FLAGS);
	wire rd_enables = reg_hit(s_axi_araddr, OFF_EVENT_ENABLES);
	wire rd_summary = reg_hit(s_axi_araddr, OFF_IRQ_SUMMARY);
	wire rd_dir = reg_hit(s_axi_araddr, OFF_DIR_SELECT);
	wire rd_mapped = rd_status | rd_flags | rd_enables | rd_summary | rd_dir | (|rd_thresh);

	// read mux; reserved bits are masked even though they never set
	logic [31:0] thr_word;
	always_comb begin
		thr_word = ZERO_WORD;
		for (int i = 0; i < NUM_BUF; i++) begin
			if (rd_thresh[i]) begin
				thr_word = thresh_ff[i];
			end
		end
	end
	wire [31:0] rd_word =
		rd_flags ? (flags_ff & ~RSVD_MASK) :
		rd_status ? (level_vec & ~RSVD_MASK) :
		rd_enables ? enables_ff :
		rd_summary ? {30'h0000_0000, summary_ff} :
		rd_dir ? {24'h00_0000, dir_ff} :
		thr_word;

	// flag clear on a read of the flags word; set wins over the clear
	wire flags_clear = ar_take & rd_flags;
	assign nxt_flags = ((flags_ff & ~({32{flags_clear}})) | set_vec) & ~RSVD_MASK;

	// enable writes honour byte strobes, reserved bits stay zero
	assign nxt_enables = (do_write & wr_enables) ?
		(strb_merge(enables_ff, wdata_ff, wstrb_ff) & ~RSVD_MASK) : enables_ff;

	// summary bits: enabled hardware sets, write one to clear, set wins
	wire [31:0] set_en = set_vec & enables_ff;
	wire set_lower = |set_en[LOWER_W-1:0];
	wire set_upper = |set_en[TOP_BIT:LOWER_W];
	wire [1:0] sum_clr = (do_write & wr_summary & wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0;
	assign nxt_summary[SUM_LOWER] = set_lower | (summary_ff[SUM_LOWER] & ~sum_clr[SUM_LOWER]);
	assign nxt_summary[SUM_UPPER] = set_upper | (summary_ff[SUM_UPPER] & ~sum_clr[SUM_UPPER]);

	// flag, enable and summary registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_ff <= FLAGS_RESET;
			enables_ff <= ENABLES_RESET;
			summary_ff <= 2'h0;
			irq_upper_ff <= 1'b0;
			irq_lower_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			enables_ff <= nxt_enables;
			summary_ff <= nxt_summary;
			irq_upper_ff <= nxt_summary[SUM_UPPER];
			irq_lower_ff <= nxt_summary[SUM_LOWER];
		end
	end

	// threshold and direction settings for the comparators
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_BUF; i++) begin
				thresh_ff[i] <= ZERO_WORD;
			end
			dir_ff <= 8'h00;
		end else if (do_write) begin
			for (int i = 0; i < NUM_BUF; i++) begin
				if (wr_thresh[i]) begin
					thresh_ff[i] <= strb_merge(thresh_ff[i], wdata_ff, wstrb_ff);
				end
			end
			if (wr_dir & wstrb_ff[0]) begin
				dir_ff <= wdata_ff[7:0] & DIR_MASK;
			end
		end
	end

	// write channel: address and data held independently, either order
	wire nxt_aw_held = aw_take | (aw_held_ff & ~do_write);
	wire nxt_w_held = w_take | (w_held_ff & ~do_write);
	wire nxt_bvalid = do_write | (bvalid_ff & ~b_done);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= ZERO_WORD;
			wstrb_ff <= 4'h0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			// one write in flight: ready again once the response is gone
			awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
			wready_ff <= ~nxt_w_held & ~nxt_bvalid;
			bvalid_ff <= nxt_bvalid;
			if (do_write) begin
				bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// read channel: data captured at accept, so the clear and the read agree
	wire nxt_rvalid = ar_take | (rvalid_ff & ~r_done);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= ZERO_WORD;
			rresp_ff <= RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_take) begin
				rdata_ff <= rd_mapped ? rd_word : ZERO_WORD;
				rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign irq_upper = irq_upper_ff;
	assign irq_lower = irq_lower_ff;
endmodule // dbef_top

// ---- dbef_checker.sv ----
`timescale 1ns/1ps
module dbef_checker
	import dbef_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// buffer side
	input wire logic [3:0] cell_committed,
	input wire logic [3:0] stamp_release,
	input wire logic [3:0] stamp_expired,
	input wire logic [3:0] no_space,
	input wire logic [3:0] no_data,
	input wire logic irq_lower
);
	logic [31:0] seen_ff, snap_ff, nxt_seen, ev_word;
	logic rd_flags_ff, ar_take, lo_cause;
	// pulse events placed in their lanes; level flags are not tracked here
	always_comb begin
		ev_word = 32'h0000_0000;
		for (int n = 0; n < 4; n++) begin
			ev_word[8*n+BIT_CELL] = cell_committed[n];
			ev_word[8*n+BIT_REL] = stamp_release[n];
			ev_word[8*n+BIT_EXP] = stamp_expired[n];
		end
	end
	// a flags read clears, but an event in that cycle survives
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign nxt_seen = ((ar_take && s_axi_araddr == OFF_EVENT_FLAGS) ? ZERO_WORD : seen_ff) | ev_word;
	assign lo_cause = |{cell_committed[1:0], stamp_release[1:0], stamp_expired[1:0],
		no_space[1:0], no_data[1:0]};
	// expected pulse flags at each read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen_ff <= ZERO_WORD;
			snap_ff <= ZERO_WORD;
			rd_flags_ff <= 1'b0;
		end else begin
			seen_ff <= nxt_seen;
			snap_ff <= ar_take ? seen_ff : snap_ff;
			rd_flags_ff <= ar_take ? (s_axi_araddr == OFF_EVENT_FLAGS) : rd_flags_ff;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_write_answer: assert property (wr_taken |=> resp_late)
		else $error("write response not two edges after transfer");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_read_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read data late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken with data pending");
	a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken with response pending");
	a_rsvd_zero: assert property (s_axi_rvalid && rd_flags_ff |->
		(s_axi_rdata & RSVD_MASK) == ZERO_WORD)
		else $error("reserved flag bits not zero");
	a_event_latch: assert property (s_axi_rvalid && rd_flags_ff |->
		(s_axi_rdata & 32'he0e0_e0e0) == snap_ff)
		else $error("event flags differ from events seen");
	// summary and interrupt line load on the same edge as the event
	a_lower_cause: assert property ($rose(irq_lower) |-> $past(lo_cause))
		else $error("lower interrupt without a lower lane event");
endmodule // dbef_checker

bind dbef_top dbef_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cell_committed,
	.stamp_release, .stamp_expired, .no_space, .no_data, .irq_lower);

// ---- test_data_buffer_event_flags.sv ----
`timescale 1ns/1ps
module test_data_buffer_event_flags import dbef_pkg::*;;
	logic aclk, aresetn;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, cell_committed, stamp_release, stamp_expired, no_space, no_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_upper, irq_lower;
	logic [47:0] level_count;
	int err_total, n_tests;
	// edges to wait before raising bready or rready, to exercise held responses
	int lag;
	int bit_of[5] = '{BIT_CELL, BIT_REL, BIT_EXP, BIT_FULL, BIT_EMPTY};
	dbef_top #(.CNT_W(12), .ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cell_committed,
		.stamp_release, .stamp_expired, .no_space, .no_data, .level_count, .irq_upper, .irq_lower);
	// 100 MHz
	always #5 aclk = ~aclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// both halves offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw;
		logic w;
		aw = 1;
		w = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		repeat (lag) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		resp = s_axi_bresp;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (lag) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		resp = s_axi_rresp;
	endtask
	// one-cycle event or level on buffer n
	task automatic pulse(input int k, input int n);
		case (k)
			0: cell_committed[n] <= 1'b1;
			1: stamp_release[n] <= 1'b1;
			2: stamp_expired[n] <= 1'b1;
			3: no_space[n] <= 1'b1;
			default: no_data[n] <= 1'b1;
		endcase
		@(posedge aclk);
		{cell_committed, stamp_release, stamp_expired, no_space, no_data} <= 20'h0_0000;
		@(posedge aclk);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#200000;
		err_total++;
		results();
	end
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 62'h0;
		{cell_committed, stamp_release, stamp_expired, no_space, no_data} = 20'h0_0000;
		level_count = 48'h0000_0000_0000;
		s_axi_wstrb = 4'hf;
		s_axi_bready = 1'b0;
		s_axi_rready = 1'b0;
		lag = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, FLAGS_RESET);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, ZERO_WORD);
		$display("test reset done");
		for (int n = 0; n < 4; n++) begin
			for (int k = 0; k < 5; k++) begin
				pulse(k, n);
				rd(OFF_EVENT_FLAGS, d, r);
				chk(d, 32'h0000_0001 << (8*n+bit_of[k]));
			end
		end
		$display("test lanes done");
		// event lands on the very edge that takes the clearing read
		fork
			rd(OFF_EVENT_FLAGS, d, r);
			pulse(0, 1);
		join
		chk(d, ZERO_WORD);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, 32'h0000_8000);
		$display("test set wins done");
		// from here on responses wait two edges for the master's ready
		lag = 2;
		wr(OFF_EVENT_FLAGS, 32'hffff_ffff, r);
		chk(32'(r), 32'(RESP_OKAY));
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, ZERO_WORD);
		wr(OFF_EVENT_ENABLES, 32'hffff_ffff, r);
		rd(OFF_EVENT_ENABLES, d, r);
		chk(d, ~RSVD_MASK);
		wr(OFF_EVENT_ENABLES, ZERO_WORD, r);
		wr(12'h200, 32'h1234_5678, r);
		chk(32'(r), 32'(RESP_SLVERR));
		rd(12'h200, d, r);
		chk(d, ZERO_WORD);
		chk(32'(r), 32'(RESP_SLVERR));
		$display("test access done");
		// buffer 2: first mark at 10, second at 20
		wr(OFF_THRESH_BASE + 12'h008, 32'h0014_000a, r);
		level_count[24 +: 12] <= 12'h00f;
		repeat (4) @(posedge aclk);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, 32'h0008_0000);
		level_count[24 +: 12] <= 12'h019;
		repeat (4) @(posedge aclk);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, 32'h0010_0000);
		repeat (4) @(posedge aclk);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, ZERO_WORD);
		// buffer 0 first mark trips below 5 once direction flips
		wr(OFF_THRESH_BASE, 32'h0000_0005, r);
		wr(OFF_DIR_SELECT, 32'h0000_0001, r);
		repeat (4) @(posedge aclk);
		rd(OFF_EVENT_FLAGS, d, r);
		chk(d, 32'h0000_0008);
		$display("test marks done");
		wr(OFF_EVENT_ENABLES, 32'h0080_0080, r);
		wr(OFF_IRQ_SUMMARY, 32'h0000_0003, r);
		repeat (2) @(posedge aclk);
		chk(32'({irq_upper, irq_lower}), 32'h0000_0000);
		pulse(0, 0);
		@(posedge aclk);
		chk(32'({irq_upper, irq_lower}), 32'h0000_0001);
		pulse(0, 2);
		@(posedge aclk);
		chk(32'({irq_upper, irq_lower}), 32'h0000_0003);
		wr(OFF_EVENT_ENABLES, ZERO_WORD, r);
		wr(OFF_IRQ_SUMMARY, 32'h0000_0003, r);
		pulse(0, 2);
		@(posedge aclk);
		chk(32'({irq_upper, irq_lower}), 32'h0000_0000);
		$display("test summary done");
		results();
	end
endmodule // test_data_buffer_event_flags
